// ---- sram_port_consts.vh ----
// constants for the asynchronous byte-wide static memory controller
// assumes a 40 MHz system clock; included by the controller files
`ifndef SRAM_PORT_CONSTS_VH
`define SRAM_PORT_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADDR_W 16
`define DATA_W 8
`define CNT_W 4

// ----------------------------------------------------------------
// clock and timing (ns as printed, cycles derived)
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define T_RC_NS 15
`define T_WC_NS 15
`define T_PWE_NS 12
`define T_SD_NS 8
`define T_AA_NS 15
`define T_HZWE_NS 7
// least times round up, never below one cycle
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define RD_CYC `CYC_UP(`T_RC_NS + `T_AA_NS)
`define WR_CYC `CYC_UP(`T_WC_NS)
`define PWE_CYC `CYC_UP(`T_PWE_NS + `T_HZWE_NS)

`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

`endif

// ---- cycle_timer.v ----
// down counter that measures a minimum number of clock cycles
// assumes load and the count come from the controller, same clock
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_consts.vh"

module cycle_timer (
    input wire clk,
    input wire rst_n,
    input wire load,
    input wire [`CNT_W-1:0] load_val,
    output wire done
);

    reg [`CNT_W-1:0] cnt_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `CNT_ZERO;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != `CNT_ZERO) begin
            cnt_r <= cnt_r - `CNT_ONE;
        end
    end

    assign done = (cnt_r == `CNT_ZERO);

endmodule
`default_nettype wire

// ---- sram_port_ctrl.v ----
// controller that drives a 64k x 8 asynchronous static memory
// assumes one request at a time on req_valid/req_ready; memory inputs synchronous
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_consts.vh"

module sram_port_ctrl (
    input wire clk,
    input wire rst_n,
    input wire req_valid,
    input wire req_write,
    input wire [`ADDR_W-1:0] req_addr,
    input wire [`DATA_W-1:0] req_wdata,
    output wire req_ready,
    output reg rsp_valid,
    output reg [`DATA_W-1:0] rsp_rdata,
    output reg [`ADDR_W-1:0] addr_lines,
    output reg select_active_low_n,
    output reg select_active_high,
    output reg out_gate_n,
    output reg write_strobe_n,
    input wire [`DATA_W-1:0] data_lines_in,
    output reg [`DATA_W-1:0] data_lines_out,
    output reg data_lines_oe
);

    // ----------------------------------------------------------------
    // state and timer
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RD = 3'h1;
    localparam [2:0] ST_WR_OFF = 3'h2;
    localparam [2:0] ST_WR = 3'h3;
    localparam [2:0] ST_WR_END = 3'h4;

    // cycle figures are integers; cut to the timer width on purpose
    localparam integer RD_CYC_I = `RD_CYC;
    localparam integer PWE_CYC_I = `PWE_CYC;
    localparam [`CNT_W-1:0] RD_LOAD = RD_CYC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] PWE_LOAD = PWE_CYC_I[`CNT_W-1:0];

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg tmr_load;
    reg [`CNT_W-1:0] tmr_val;
    wire tmr_done;
    reg [`ADDR_W-1:0] addr_lines_nxt;
    reg select_active_low_n_nxt;
    reg select_active_high_nxt;
    reg out_gate_n_nxt;
    reg write_strobe_n_nxt;
    reg [`DATA_W-1:0] data_lines_out_nxt;
    reg data_lines_oe_nxt;
    reg rsp_valid_nxt;
    reg [`DATA_W-1:0] rsp_rdata_nxt;

    cycle_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // ----------------------------------------------------------------
    // request side
    // ----------------------------------------------------------------
    // one access at a time, so no request is ever queued
    assign req_ready = (state_r == ST_IDLE);

    // ----------------------------------------------------------------
    // timer control
    // ----------------------------------------------------------------
    // done shows as soon as the count is zero and the state leaves one edge later, so each phase lasts load + 1 cycles
    always @* begin
        tmr_load = 1'b0;
        tmr_val = `CNT_ZERO;
        if (state_r == ST_IDLE && req_valid) begin
            tmr_load = 1'b1;
            if (req_write) begin
                tmr_val = PWE_LOAD;
            end else begin
                tmr_val = RD_LOAD;
            end
        end else if (state_r == ST_WR_OFF) begin
            tmr_load = 1'b1;
            tmr_val = PWE_LOAD;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (req_valid && req_write) begin
                    state_nxt = ST_WR_OFF;
                end else if (req_valid) begin
                    state_nxt = ST_RD;
                end
            end
            ST_RD: begin
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WR_OFF: begin
                // one cycle with the gate high before the bus is driven
                state_nxt = ST_WR;
            end
            ST_WR: begin
                if (tmr_done) begin
                    state_nxt = ST_WR_END;
                end
            end
            ST_WR_END: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                // unused codes fall back to idle
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next values of the memory pins and the answer
    // ----------------------------------------------------------------
    always @* begin
        addr_lines_nxt = addr_lines;
        select_active_low_n_nxt = select_active_low_n;
        select_active_high_nxt = select_active_high;
        out_gate_n_nxt = out_gate_n;
        write_strobe_n_nxt = write_strobe_n;
        data_lines_out_nxt = data_lines_out;
        data_lines_oe_nxt = data_lines_oe;
        rsp_valid_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata;
        case (state_r)
            ST_IDLE: begin
                if (req_valid) begin
                    // address set with the selects in the same edge
                    addr_lines_nxt = req_addr;
                    select_active_low_n_nxt = 1'b0;
                    select_active_high_nxt = 1'b1;
                    write_strobe_n_nxt = 1'b1;
                    if (req_write) begin
                        // gate stays high so the memory never drives
                        out_gate_n_nxt = 1'b1;
                        data_lines_out_nxt = req_wdata;
                    end else begin
                        out_gate_n_nxt = 1'b0;
                        data_lines_oe_nxt = 1'b0;
                    end
                end
            end
            ST_RD: begin
                if (tmr_done) begin
                    // data sampled before selects drop, inside the hold time
                    rsp_rdata_nxt = data_lines_in;
                    rsp_valid_nxt = 1'b1;
                    out_gate_n_nxt = 1'b1;
                    select_active_low_n_nxt = 1'b1;
                    select_active_high_nxt = 1'b0;
                end
            end
            ST_WR_OFF: begin
                // bus drive only starts once the memory gate is off
                data_lines_oe_nxt = 1'b1;
                write_strobe_n_nxt = 1'b0;
            end
            ST_WR: begin
                if (tmr_done) begin
                    // only the strobe ends the window; data still held
                    write_strobe_n_nxt = 1'b1;
                end
            end
            ST_WR_END: begin
                // release after the ending edge: zero hold is enough
                data_lines_oe_nxt = 1'b0;
                // gate still high, so deselect never exposes read data
                select_active_low_n_nxt = 1'b1;
                select_active_high_nxt = 1'b0;
                rsp_valid_nxt = 1'b1;
            end
            default: begin
                rsp_valid_nxt = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // pin registers
    // ----------------------------------------------------------------
    // every memory pin leaves a flip-flop, so no glitch reaches the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            addr_lines <= {`ADDR_W{1'b0}};
            select_active_low_n <= 1'b1;
            select_active_high <= 1'b0;
            out_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_lines_out <= {`DATA_W{1'b0}};
            data_lines_oe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {`DATA_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            addr_lines <= addr_lines_nxt;
            select_active_low_n <= select_active_low_n_nxt;
            select_active_high <= select_active_high_nxt;
            out_gate_n <= out_gate_n_nxt;
            write_strobe_n <= write_strobe_n_nxt;
            data_lines_out <= data_lines_out_nxt;
            data_lines_oe <= data_lines_oe_nxt;
            rsp_valid <= rsp_valid_nxt;
            rsp_rdata <= rsp_rdata_nxt;
        end
    end

endmodule
`default_nettype wire

// ---- sram_port_ctrl_asserts.sv ----
// pin-level checks of the static memory controller
// assumes binding into sram_port_ctrl, one clock domain
`timescale 1ns/100ps
`default_nettype none
module sram_port_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rsp_valid,
    input wire logic [15:0] addr_lines,
    input wire logic select_active_low_n,
    input wire logic select_active_high,
    input wire logic out_gate_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RD_STROBE: assert property (!out_gate_n |-> write_strobe_n) else $error("strobe low in read");
    AST_NO_FIGHT: assert property (data_lines_oe |-> out_gate_n) else $error("bus driven with gate low");
    AST_WR_WIN: assert property (!write_strobe_n |-> data_lines_oe && out_gate_n && !select_active_low_n
        && select_active_high) else $error("write window badly formed");
    AST_DATA_HOLD: assert property ($rose(write_strobe_n) |-> data_lines_oe && $stable(data_lines_out))
        else $error("data not held at write end");
    AST_WR_END: assert property ($rose(write_strobe_n) |=> select_active_low_n && !data_lines_oe)
        else $error("no release after write");
    AST_ADDR_SEL: assert property (!select_active_low_n && $past(!select_active_low_n) |-> $stable(addr_lines))
        else $error("address moved while selected");
    AST_PWE: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
        else $error("strobe width wrong");
    AST_RD_LEN: assert property ($fell(out_gate_n) |-> !out_gate_n[*2] ##[1:3] out_gate_n)
        else $error("read cycle length wrong");
    AST_RD_RSP: assert property ($rose(out_gate_n) |-> rsp_valid) else $error("read ended without answer");
endmodule
bind sram_port_ctrl sram_port_ctrl_asserts i_sram_port_ctrl_asserts (.clk(clk), .rst_n(rst_n),
    .rsp_valid(rsp_valid), .addr_lines(addr_lines), .select_active_low_n(select_active_low_n),
    .select_active_high(select_active_high), .out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
`default_nettype wire

// ---- sram_mem_model.sv ----
// behavioural 64k x 8 static memory
// assumes the bench resolves the data wires
`timescale 1ns/100ps
`default_nettype none
module sram_mem_model (
    input wire logic [15:0] addr_lines,
    input wire logic select_active_low_n,
    input wire logic select_active_high,
    input wire logic out_gate_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] bus,
    output logic [7:0] dq_o,
    output logic dq_en
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    wire sel = !select_active_low_n && select_active_high;
    assign dq_en = sel && !out_gate_n && write_strobe_n;
    always @* if (sel && !write_strobe_n) mem[addr_lines] = bus;
    always @* if (dq_en) last = mem[addr_lines];
    // released wires show the inverse, never a stale match
    assign dq_o = dq_en ? mem[addr_lines] : ~last;
endmodule
`default_nettype wire

// ---- sram_port_ctrl_tb.sv ----
// self-checking bench for the static memory controller
// assumes sram_mem_model on the memory pins
`timescale 1ns/100ps
`default_nettype none
module sram_port_ctrl_tb;
    logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00;
    wire req_ready, rsp_valid, sel_n, sel_h, gate_n, strobe_n, oe, dq_en;
    wire [7:0] rsp_rdata, dout, dq_o;
    wire [15:0] addr;
    wire [7:0] bus = oe ? dout : dq_o;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #12.5 clk = ~clk;
    sram_port_ctrl i_sram_port_ctrl (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .addr_lines(addr), .select_active_low_n(sel_n), .select_active_high(sel_h),
        .out_gate_n(gate_n), .write_strobe_n(strobe_n), .data_lines_in(bus), .data_lines_out(dout),
        .data_lines_oe(oe));
    sram_mem_model i_sram_mem_model (.addr_lines(addr), .select_active_low_n(sel_n), .select_active_high(sel_h),
        .out_gate_n(gate_n), .write_strobe_n(strobe_n), .bus(bus), .dq_o(dq_o), .dq_en(dq_en));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        n = 0;
        do @(negedge clk); while (req_ready !== 1'b1 && ++n < 20);
        chk({7'h00, n < 20}, 8'h01);
        @(posedge clk);
        req_valid <= 0;
        n = 0;
        do begin @(posedge clk); #1; end while (rsp_valid !== 1'b1 && ++n < 20);
        chk({7'h00, n < 20}, 8'h01);
    endtask
    task automatic t_reset;
        #1;
        chk({1'b0, dq_en, sel_n, sel_h, gate_n, strobe_n, oe, req_ready}, 8'h2d);
        $display("test reset done");
    endtask
    task automatic t_rw;
        logic [15:0] tab [4] = '{16'h0000, 16'hffff, 16'h1234, 16'h8001};
        foreach (tab[i]) begin
            xfer(1, tab[i], tab[i][7:0] ^ 8'ha5);
            chk(i_sram_mem_model.mem[tab[i]], tab[i][7:0] ^ 8'ha5);
            xfer(0, tab[i], 8'h00);
            chk(rsp_rdata, tab[i][7:0] ^ 8'ha5);
        end
        $display("test rw done");
    endtask
    task automatic t_over;
        xfer(1, 16'hffff, 8'h3c);
        xfer(1, 16'h0000, 8'hc3);
        xfer(0, 16'hffff, 8'h00);
        chk(rsp_rdata, 8'h3c);
        xfer(0, 16'h0000, 8'h00);
        chk(rsp_rdata, 8'hc3);
        $display("test overwrite done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // limit well above the dozen short transfers
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_reset;
        t_rw;
        t_over;
        give_verdict;
    end
endmodule
`default_nettype wire
